// *** include/pta_pkg.sv ***
// constants and carrier types for the pci target access block
// assumes a single 10 MHz pci-side clock and active-low pci pin levels
// Notes on behaviour
// - six init sources, fixed precedence order
// - software-reset resources also cleared by hard resets
// - act as target for control/status and flash
// - separate bars: 4 KB mem, 64 B io
// - control/status accesses: one phase, zero waits
// - control/status read: data with trdy, stop
// - control/status write: trdy, one phase, stop
// - flash access disconnects at first data phase
// - flash read: wait states, then trdy with data
// - flash write: trdy only after flash written; rejected byte enables get trdy at once
// - flash reads byte or 16-bit only
// - flash writes carry exactly one byte
// - retry config cycles until eeprom load done
// - no delayed-transaction state for retried masters
// - after load, complete every access normally
// - data parity error: status 15, perr if cmd6
// - config accesses also disconnect after data
// - address parity error: status 15, serr/14 only if cmd8 and cmd6
package pta_pkg;
    localparam logic [3:0] CMD_IO_RD = 4'h2;
    localparam logic [3:0] CMD_IO_WR = 4'h3;
    localparam logic [3:0] CMD_MEM_RD = 4'h6;
    localparam logic [3:0] CMD_MEM_WR = 4'h7;
    localparam logic [3:0] CMD_CFG_RD = 4'ha;
    localparam logic [3:0] CMD_CFG_WR = 4'hb;
    localparam int CSR_MEM_BITS = 12;
    localparam int CSR_IO_BITS = 6;
    localparam int FLASH_BITS = 17;
    localparam int STAT_DPE_BIT = 15;
    localparam int STAT_SSE_BIT = 14;
    localparam int CMD_PER_BIT = 6;
    localparam int CMD_SERR_BIT = 8;
    localparam logic [31:0] CSR_MEM_BAR_RST = 32'h0000_0000;
    localparam logic [31:0] CSR_IO_BAR_RST = 32'h0000_0001;
    localparam logic [31:0] FLASH_BAR_RST = 32'h0000_0000;
    localparam logic [15:0] PCI_CMD_RST = 16'h0000;
    localparam logic [15:0] PCI_STAT_RST = 16'h0000;
    localparam int FLASH_WAIT_CYC = 4;
    localparam logic [3:0] INIT_NONE = 4'h0;
    typedef struct packed {
        logic [31:0] ad;
        logic [3:0] cbeN;
        logic par;
        logic frameN;
        logic irdyN;
        logic idsel;
    } pta_bus_in_s;
    typedef struct packed {
        logic [31:0] ad;
        logic par;
    } pta_rdata_s;
    typedef enum logic [1:0] {
        TGT_CSR,
        TGT_FLASH,
        TGT_CFG
    } pta_tgt_e;
endpackage

// *** src/pta_target.sv ***
// pci target access: csr space, flash window, config space, init sources
// assumes pci pins already resolved to levels; outputs feed external pad enables
`timescale 1ns/1ns
module pta_target
    import pta_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic porN,
    input wire logic alternate_reset_pin,
    input wire logic pciRstN,
    input wire logic bus_pin_a,
    input wire logic swResetReq,
    input wire logic selResetReq,
    input wire logic d3ToD0,
    input wire logic eepromLoadDone,
    input wire pta_bus_in_s busIn,
    input wire logic [31:0] csrRdData,
    input wire logic [15:0] flashRdData,
    input wire logic flashDone,
    output logic [31:0] adOut_ff,
    output logic adOe_ff,
    output logic parOut_ff,
    output logic trdyN_ff,
    output logic stopN_ff,
    output logic devselN_ff,
    output logic ctlOe_ff,
    output logic perrN_ff,
    output logic perrOe_ff,
    output logic serrN_ff,
    output logic serrOe_ff,
    output logic csrRd_ff,
    output logic csrWr_ff,
    output logic [11:0] csrAddr_ff,
    output logic [31:0] csrWrData_ff,
    output logic [3:0] csrBe_ff,
    output logic flashRd_ff,
    output logic flashWr_ff,
    output logic [16:0] flashAddr_ff,
    output logic [7:0] flashWrData_ff,
    output logic [3:0] initSrc_ff,
    output logic hwInit_ff,
    output logic swInit_ff,
    output logic selInit_ff,
    output logic [15:0] pciStat_ff
);
    logic rstSync1_ff;
    logic rstSync2_ff;
    logic loadDone_ff;
    logic [15:0] pciCmd_ff;
    logic [31:0] csrMemBar_ff;
    logic [31:0] csrIoBar_ff;
    logic [31:0] flashBar_ff;
    logic [3:0] cmd_ff;
    logic [31:0] addr_ff;
    logic isIo_ff;
    logic frameN_d;
    logic addrPhase;
    logic [3:0] nxt_initSrc;
    logic dataPar;
    logic parChk_ff;
    logic parChkAddr_ff;
    logic dataPhase_ff;
    logic hitCsrMem;
    logic hitCsrIo;
    logic hitFlash;
    logic hitCfg;
    logic beOk;
    pta_tgt_e tgt_ff;

    typedef enum logic [2:0] {
        S_IDLE,
        S_WAIT,
        S_FLASH,
        S_DATA,
        S_DONE,
        S_TURN
    } pta_state_e;
    pta_state_e state_ff;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rstSync1_ff <= 1'b0;
            rstSync2_ff <= 1'b0;
        end else begin
            rstSync1_ff <= 1'b1;
            rstSync2_ff <= rstSync1_ff;
        end
    end
    wire rstN = rstSync2_ff;

    // highest-priority active source wins; 1..6 code its rank
    always_comb begin
        nxt_initSrc = INIT_NONE;
        if (!porN) nxt_initSrc = 4'h1;
        else if (!alternate_reset_pin) nxt_initSrc = 4'h2;
        else if (!pciRstN) nxt_initSrc = 4'h3;
        else if (!bus_pin_a) nxt_initSrc = 4'h4;
        else if (swResetReq) nxt_initSrc = 4'h5;
        else if (selResetReq) nxt_initSrc = 4'h6;
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            initSrc_ff <= INIT_NONE;
            hwInit_ff <= 1'b1;
            swInit_ff <= 1'b1;
            selInit_ff <= 1'b1;
        end else begin
            initSrc_ff <= nxt_initSrc;
            hwInit_ff <= nxt_initSrc inside {4'h1, 4'h2, 4'h3, 4'h4};
            // software-reset domain is a superset target of hard resets
            swInit_ff <= nxt_initSrc inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h5} || d3ToD0;
            selInit_ff <= nxt_initSrc != INIT_NONE || d3ToD0;
        end
    end

    // flag re-armed by each hardware source, set by the loader
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            loadDone_ff <= 1'b0;
        end else if (nxt_initSrc inside {4'h1, 4'h2, 4'h3, 4'h4}) begin
            loadDone_ff <= 1'b0;
        end else if (eepromLoadDone) begin
            loadDone_ff <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) frameN_d <= 1'b1;
        else frameN_d <= busIn.frameN;
    end
    assign addrPhase = !busIn.frameN && frameN_d && state_ff == S_IDLE;

    // separate bars, masked to 4 KB mem, 64 B io, 128 KB flash
    assign hitCsrMem = busIn.cbeN inside {CMD_MEM_RD, CMD_MEM_WR} &&
        busIn.ad[31:CSR_MEM_BITS] == csrMemBar_ff[31:CSR_MEM_BITS];
    assign hitCsrIo = busIn.cbeN inside {CMD_IO_RD, CMD_IO_WR} &&
        busIn.ad[31:CSR_IO_BITS] == csrIoBar_ff[31:CSR_IO_BITS];
    assign hitFlash = busIn.cbeN inside {CMD_MEM_RD, CMD_MEM_WR} &&
        busIn.ad[31:FLASH_BITS] == flashBar_ff[31:FLASH_BITS];
    assign hitCfg = busIn.idsel && busIn.cbeN inside {CMD_CFG_RD, CMD_CFG_WR} &&
        busIn.ad[1:0] == 2'b00;

    // flash reads byte or 16-bit; writes exactly one byte
    always_comb begin
        if (cmd_ff == CMD_MEM_WR)
            beOk = busIn.cbeN inside {4'he, 4'hd, 4'hb, 4'h7};
        else
            beOk = busIn.cbeN inside {4'he, 4'hd, 4'hb, 4'h7, 4'hc, 4'h3};
    end

    // main target sequencer; no per-master retry bookkeeping
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            state_ff <= S_IDLE;
            tgt_ff <= TGT_CSR;
            cmd_ff <= 4'h0;
            addr_ff <= 32'h0000_0000;
            isIo_ff <= 1'b0;
            devselN_ff <= 1'b1;
            trdyN_ff <= 1'b1;
            stopN_ff <= 1'b1;
            ctlOe_ff <= 1'b0;
            adOe_ff <= 1'b0;
            adOut_ff <= 32'h0000_0000;
            csrRd_ff <= 1'b0;
            csrWr_ff <= 1'b0;
            csrAddr_ff <= 12'h000;
            csrWrData_ff <= 32'h0000_0000;
            csrBe_ff <= 4'h0;
            flashRd_ff <= 1'b0;
            flashWr_ff <= 1'b0;
            flashAddr_ff <= 17'h0_0000;
            flashWrData_ff <= 8'h00;
            csrMemBar_ff <= CSR_MEM_BAR_RST;
            csrIoBar_ff <= CSR_IO_BAR_RST;
            flashBar_ff <= FLASH_BAR_RST;
            pciCmd_ff <= PCI_CMD_RST;
        end else begin
            csrRd_ff <= 1'b0;
            csrWr_ff <= 1'b0;
            flashRd_ff <= 1'b0;
            flashWr_ff <= 1'b0;
            if (hwInit_ff || d3ToD0) begin
                csrMemBar_ff <= CSR_MEM_BAR_RST;
                csrIoBar_ff <= CSR_IO_BAR_RST;
                flashBar_ff <= FLASH_BAR_RST;
                pciCmd_ff <= PCI_CMD_RST;
            end
            case (state_ff)
                S_IDLE: begin
                    if (addrPhase && (hitCfg || hitCsrMem || hitCsrIo || hitFlash)) begin
                        state_ff <= S_WAIT;
                        cmd_ff <= busIn.cbeN;
                        addr_ff <= busIn.ad;
                        isIo_ff <= hitCsrIo;
                        // latched early: csr back end answers in the first data clock
                        csrAddr_ff <= hitCsrIo ? {6'h00, busIn.ad[CSR_IO_BITS-1:0]} :
                            busIn.ad[CSR_MEM_BITS-1:0];
                        tgt_ff <= hitCfg ? TGT_CFG : (hitFlash && !hitCsrMem) ?
                            TGT_FLASH : TGT_CSR;
                        devselN_ff <= 1'b0;
                        ctlOe_ff <= 1'b1;
                    end
                end
                S_WAIT: begin
                    if (tgt_ff == TGT_CFG && !loadDone_ff) begin
                        // retry: stop without trdy
                        stopN_ff <= 1'b0;
                        state_ff <= S_DONE;
                    end else if (!busIn.irdyN) begin
                        if (tgt_ff == TGT_FLASH) begin
                            flashAddr_ff <= addr_ff[16:0];
                            flashWrData_ff <= busIn.cbeN[0] ? (busIn.cbeN[1] ?
                                (busIn.cbeN[2] ? busIn.ad[31:24] : busIn.ad[23:16]) :
                                busIn.ad[15:8]) : busIn.ad[7:0];
                            flashRd_ff <= cmd_ff == CMD_MEM_RD && beOk;
                            flashWr_ff <= cmd_ff == CMD_MEM_WR && beOk;
                            state_ff <= S_FLASH;
                        end else begin
                            // one zero-wait phase, trdy with stop
                            trdyN_ff <= 1'b0;
                            stopN_ff <= 1'b0;
                            if (tgt_ff == TGT_CSR) begin
                                csrBe_ff <= ~busIn.cbeN;
                                csrRd_ff <= !cmd_ff[0];
                                csrWr_ff <= cmd_ff[0];
                                csrWrData_ff <= busIn.ad;
                                adOut_ff <= csrRdData;
                            end else begin
                                case (addr_ff[7:2])
                                    6'h01: adOut_ff <= {pciStat_ff, pciCmd_ff};
                                    6'h04: adOut_ff <= csrMemBar_ff;
                                    6'h05: adOut_ff <= csrIoBar_ff;
                                    6'h06: adOut_ff <= flashBar_ff;
                                    default: adOut_ff <= 32'h0000_0000;
                                endcase
                                if (cmd_ff == CMD_CFG_WR) begin
                                    case (addr_ff[7:2])
                                        6'h01: pciCmd_ff <= busIn.ad[15:0];
                                        6'h04: csrMemBar_ff <= {busIn.ad[31:12], 12'h000};
                                        6'h05: csrIoBar_ff <= {busIn.ad[31:6], 6'h01};
                                        6'h06: flashBar_ff <= {busIn.ad[31:17], 17'h0_0000};
                                        default: ;
                                    endcase
                                end
                            end
                            adOe_ff <= !cmd_ff[0];
                            state_ff <= S_DATA;
                        end
                    end
                end
                S_FLASH: begin
                    // trdy withheld until flash finishes; rejected byte enables get it at once
                    if (flashDone || !beOk) begin
                        trdyN_ff <= 1'b0;
                        stopN_ff <= 1'b0;
                        adOut_ff <= {flashRdData, flashRdData};
                        adOe_ff <= cmd_ff == CMD_MEM_RD;
                        state_ff <= S_DATA;
                    end
                end
                S_DATA: begin
                    trdyN_ff <= 1'b1;
                    adOe_ff <= 1'b0;
                    state_ff <= S_DONE;
                end
                S_DONE: begin
                    if (busIn.frameN) begin
                        stopN_ff <= 1'b1;
                        devselN_ff <= 1'b1;
                        state_ff <= S_TURN;
                    end
                end
                S_TURN: begin
                    ctlOe_ff <= 1'b0;
                    state_ff <= S_IDLE;
                end
                default: state_ff <= S_IDLE;
            endcase
        end
    end

    assign dataPar = ^{busIn.ad, busIn.cbeN};

    // parity checked the clock after each address or written data phase
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            parChk_ff <= 1'b0;
            parChkAddr_ff <= 1'b0;
            dataPhase_ff <= 1'b0;
            parOut_ff <= 1'b0;
        end else begin
            parChkAddr_ff <= !busIn.frameN && frameN_d;
            dataPhase_ff <= state_ff == S_WAIT && !busIn.irdyN && cmd_ff[0] &&
                !(tgt_ff == TGT_CFG && !loadDone_ff);
            parChk_ff <= dataPar;
            parOut_ff <= ^{adOut_ff, cbeForPar(busIn.cbeN)};
        end
    end

    function automatic logic [3:0] cbeForPar(input logic [3:0] c);
        cbeForPar = c;
    endfunction

    wire parBad = parChk_ff != busIn.par;

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            pciStat_ff <= PCI_STAT_RST;
            perrN_ff <= 1'b1;
            perrOe_ff <= 1'b0;
            serrN_ff <= 1'b1;
            serrOe_ff <= 1'b0;
        end else begin
            perrN_ff <= 1'b1;
            serrN_ff <= 1'b1;
            perrOe_ff <= !perrN_ff;
            serrOe_ff <= 1'b0;
            if (hwInit_ff) pciStat_ff <= PCI_STAT_RST;
            // error set wins over reset clear in same cycle
            if (dataPhase_ff && parBad) begin
                pciStat_ff[STAT_DPE_BIT] <= 1'b1;
                if (pciCmd_ff[CMD_PER_BIT]) begin
                    perrN_ff <= 1'b0;
                    perrOe_ff <= 1'b1;
                end
            end
            if (parChkAddr_ff && parBad) begin
                pciStat_ff[STAT_DPE_BIT] <= 1'b1;
                if (pciCmd_ff[CMD_SERR_BIT] && pciCmd_ff[CMD_PER_BIT]) begin
                    pciStat_ff[STAT_SSE_BIT] <= 1'b1;
                    serrN_ff <= 1'b0;
                    serrOe_ff <= 1'b1;
                end
            end
        end
    end

    // after load, config cycles complete with data
    cfg_ok_a: assert property (@(posedge clk) disable iff (!rstN)
        state_ff == S_WAIT && tgt_ff == TGT_CFG && loadDone_ff && !busIn.irdyN
        |=> !trdyN_ff && !stopN_ff) else $error("config not completed");
    retry_a: assert property (@(posedge clk) disable iff (!rstN)
        state_ff == S_WAIT && tgt_ff == TGT_CFG && !loadDone_ff
        |=> trdyN_ff && !stopN_ff) else $error("config not retried");
    sequence csr_go;
        state_ff == S_WAIT && tgt_ff == TGT_CSR && !busIn.irdyN;
    endsequence
    csr_zero_a: assert property (@(posedge clk) disable iff (!rstN)
        csr_go |=> !trdyN_ff ##1 trdyN_ff) else $error("csr phase not single");
    stop_trdy_a: assert property (@(posedge clk) disable iff (!rstN)
        !trdyN_ff |-> !stopN_ff) else $error("trdy without stop");
    flash_wait_a: assert property (@(posedge clk) disable iff (!rstN)
        state_ff == S_FLASH && !flashDone && beOk |=> trdyN_ff)
        else $error("flash trdy early");
    flash_wr1_a: assert property (@(posedge clk) disable iff (!rstN)
        flashWr_ff |-> $past(busIn.cbeN) inside {4'he, 4'hd, 4'hb, 4'h7})
        else $error("multi-byte flash write");
    rd_data_a: assert property (@(posedge clk) disable iff (!rstN)
        !trdyN_ff && !cmd_ff[0] |-> adOe_ff) else $error("read data not driven");
    serr_one_a: assert property (@(posedge clk) disable iff (!rstN)
        !serrN_ff |=> serrN_ff && pciStat_ff[STAT_SSE_BIT])
        else $error("serr not one clock");
    dpe_set_a: assert property (@(posedge clk) disable iff (!rstN)
        dataPhase_ff && parBad |=> pciStat_ff[STAT_DPE_BIT])
        else $error("parity error not logged");
    load_clr_a: assert property (@(posedge clk) disable iff (!rstN)
        !porN |=> !loadDone_ff) else $error("load flag not cleared");
    init_prio_a: assert property (@(posedge clk) disable iff (!rstN)
        !porN |=> initSrc_ff == 4'h1) else $error("init precedence wrong");
endmodule

// *** verification/pta_host_model.sv ***
// host initiator model: drives the pci bus pins for single data phase transfers
// assumes inputs change on the falling edge; target outputs are registered
`timescale 1ns/1ns
module pta_host_model
    import pta_pkg::*;
(
    input wire logic clk,
    input wire logic trdyN,
    input wire logic stopN,
    input wire logic [31:0] adIn,
    output pta_bus_in_s busIn
);
    logic flip = 1'b0;
    initial begin
        busIn = '{ad: 32'h0, cbeN: 4'hf, par: 1'b0, frameN: 1'b1, irdyN: 1'b1, idsel: 1'b0};
    end
    // parity trails ad/cbe by one clock; flip only when a scenario asks for a bad one
    always @(negedge clk) begin
        busIn.par <= ^{busIn.ad, busIn.cbeN} ^ flip;
    end
    // be is active high here, inverted onto the lanes
    task automatic xfer(input logic [3:0] cmd, input logic [31:0] addr, input logic [3:0] be,
        input logic [31:0] wdata, input logic cfg, input int waits, input logic [1:0] bad,
        output logic [31:0] rdata, output logic gotTrdy, output logic gotStop, output int lat);
        int n;
        @(negedge clk);
        busIn.frameN <= 1'b0;
        busIn.ad <= addr;
        busIn.cbeN <= cmd;
        busIn.idsel <= cfg;
        flip <= bad[0];
        @(negedge clk);
        busIn.idsel <= 1'b0;
        busIn.cbeN <= ~be;
        // released lines on reads show the inverse, never a stale address
        busIn.ad <= cmd[0] ? wdata : ~addr;
        // one write of flip per edge: a bad data parity lands with irdy
        flip <= (waits == 0) ? bad[1] : 1'b0;
        repeat (waits) @(negedge clk);
        busIn.irdyN <= 1'b0;
        busIn.frameN <= 1'b1;
        if (waits != 0) flip <= bad[1];
        lat = 0;
        for (n = 0; n < 20; n++) begin
            @(negedge clk);
            lat++;
            if (trdyN === 1'b0 || stopN === 1'b0) break;
        end
        rdata = adIn;
        gotTrdy = (trdyN === 1'b0);
        gotStop = (stopN === 1'b0);
        @(negedge clk);
        busIn.irdyN <= 1'b1;
        busIn.cbeN <= 4'hf;
        busIn.ad <= ~busIn.ad;
        flip <= 1'b0;
        repeat (3) @(negedge clk);
    endtask
endmodule

// *** verification/pci_target_access_and_init_tb_top.sv ***
// testbench: host transfers and init sources against the pci target block
// assumes pta_host_model owns the bus pins; csr and flash back ends live here
`timescale 1ns/1ns
module pci_target_access_and_init_tb_top
    import pta_pkg::*;
;
    logic clk = 1'b0, resetn = 1'b0, porN = 1'b1, alternate_reset_pin = 1'b1, pciRstN = 1'b1;
    logic bus_pin_a = 1'b1, swResetReq = 1'b0, selResetReq = 1'b0, d3ToD0 = 1'b0;
    logic eepromLoadDone = 1'b0, flashDone = 1'b0, serrSeen = 1'b0, perrSeen = 1'b0;
    pta_bus_in_s busIn;
    logic [31:0] csrRdData, adOut_ff, csrWrData_ff, lastCsrData, rd;
    logic [15:0] flashRdData, pciStat_ff;
    logic [11:0] csrAddr_ff, lastCsrAddr;
    logic [16:0] flashAddr_ff;
    logic [7:0] flashWrData_ff, lastFlashByte;
    logic [3:0] csrBe_ff, lastCsrBe, initSrc_ff;
    logic trdyN_ff, stopN_ff, perrN_ff, perrOe_ff, serrN_ff, serrOe_ff;
    logic csrWr_ff, flashRd_ff, flashWr_ff, gt, gs;
    logic adOe, devselN, csrRd, hwInit, swInit, selInit;
    logic [1:0] lastOe;
    int errCount = 0, totalChecks = 0, cycles = 0, flashCnt = 0, fwCnt = 0, frCnt = 0, lat, n;
    int rdCnt = 0;
    // read data tagged with its own address so a wrong decode shows
    assign csrRdData = {20'hc5a3e, csrAddr_ff};
    assign flashRdData = {4'h9, flashAddr_ff[11:0]};
    pta_host_model host (.clk(clk), .trdyN(trdyN_ff), .stopN(stopN_ff), .adIn(adOut_ff),
        .busIn(busIn));
    pta_target dut (.clk(clk), .resetn(resetn), .porN(porN),
        .alternate_reset_pin(alternate_reset_pin), .pciRstN(pciRstN), .bus_pin_a(bus_pin_a),
        .swResetReq(swResetReq), .selResetReq(selResetReq), .d3ToD0(d3ToD0),
        .eepromLoadDone(eepromLoadDone), .busIn(busIn), .csrRdData(csrRdData),
        .flashRdData(flashRdData), .flashDone(flashDone), .adOut_ff(adOut_ff), .adOe_ff(adOe),
        .parOut_ff(), .trdyN_ff(trdyN_ff), .stopN_ff(stopN_ff), .devselN_ff(devselN),
        .ctlOe_ff(),
        .perrN_ff(perrN_ff), .perrOe_ff(perrOe_ff), .serrN_ff(serrN_ff), .serrOe_ff(serrOe_ff),
        .csrRd_ff(csrRd), .csrWr_ff(csrWr_ff), .csrAddr_ff(csrAddr_ff),
        .csrWrData_ff(csrWrData_ff),
        .csrBe_ff(csrBe_ff), .flashRd_ff(flashRd_ff), .flashWr_ff(flashWr_ff),
        .flashAddr_ff(flashAddr_ff), .flashWrData_ff(flashWrData_ff), .initSrc_ff(initSrc_ff),
        .hwInit_ff(hwInit), .swInit_ff(swInit), .selInit_ff(selInit), .pciStat_ff(pciStat_ff));
    initial begin
        forever #50 clk = ~clk;
    end
    // flash back end: done pulse a fixed number of cycles after each request
    always @(negedge clk) begin
        flashDone <= 1'b0;
        if (flashCnt != 0) begin
            flashCnt <= flashCnt - 1;
            if (flashCnt == 1) flashDone <= 1'b1;
        end else if (flashRd_ff === 1'b1 || flashWr_ff === 1'b1) begin
            flashCnt <= FLASH_WAIT_CYC;
        end
    end
    always @(negedge clk) begin
        if (csrWr_ff === 1'b1) begin
            lastCsrAddr <= csrAddr_ff;
            lastCsrData <= csrWrData_ff;
            lastCsrBe <= csrBe_ff;
        end
        if (flashWr_ff === 1'b1) begin
            lastFlashByte <= flashWrData_ff;
            fwCnt <= fwCnt + 1;
        end
        if (flashRd_ff === 1'b1) frCnt <= frCnt + 1;
        if (csrRd === 1'b1) rdCnt <= rdCnt + 1;
        if (trdyN_ff === 1'b0) lastOe <= {adOe, devselN};
        if (serrN_ff === 1'b0 && serrOe_ff === 1'b1) serrSeen <= 1'b1;
        if (perrN_ff === 1'b0 && perrOe_ff === 1'b1) perrSeen <= 1'b1;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            errCount++;
            finishTest();
        end
    end
    task automatic finishTest();
        if (errCount == 0 && totalChecks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        totalChecks++;
        if (got !== exp) begin
            errCount++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic [3:0] cmd, input logic [31:0] a, input logic [3:0] be,
        input logic [31:0] d, input int waits, input logic [1:0] bad);
        host.xfer(cmd, a, be, d, cmd[3], waits, bad, rd, gt, gs, lat);
    endtask
    task automatic loadPulse();
        @(negedge clk);
        eepromLoadDone = 1'b1;
        @(negedge clk);
        eepromLoadDone = 1'b0;
    endtask
    task automatic setSrc(input logic [5:0] m, input logic [3:0] exp);
        @(negedge clk);
        {selResetReq, swResetReq} = m[5:4];
        {bus_pin_a, pciRstN, alternate_reset_pin, porN} = ~m[3:0];
        repeat (4) @(negedge clk);
        chk({initSrc_ff, hwInit, swInit, selInit}, {exp, exp < 4'h5, exp < 4'h6, 1'b1});
        {selResetReq, swResetReq} = 2'b00;
        {bus_pin_a, pciRstN, alternate_reset_pin, porN} = 4'hf;
        repeat (4) @(negedge clk);
    endtask
    task automatic tRetry();
        acc(CMD_CFG_RD, 32'h0000_0010, 4'hf, 32'h0, 0, 2'b00);
        chk({gt, gs}, 2'b01);
        acc(CMD_CFG_RD, 32'h0000_0018, 4'hf, 32'h0, 0, 2'b00);
        chk({gt, gs}, 2'b01);
    endtask
    task automatic tConfig();
        acc(CMD_CFG_WR, 32'h0000_0004, 4'hf, 32'h0000_0143, 0, 2'b00);
        acc(CMD_CFG_WR, 32'h0000_0010, 4'hf, 32'h1000_0000, 0, 2'b00);
        acc(CMD_CFG_WR, 32'h0000_0014, 4'hf, 32'h0000_2001, 0, 2'b00);
        acc(CMD_CFG_WR, 32'h0000_0018, 4'hf, 32'h2000_0000, 0, 2'b00);
        chk({gt, gs}, 2'b11);
        acc(CMD_CFG_RD, 32'h0000_0010, 4'hf, 32'h0, 2, 2'b00);
        chk(rd, 32'h1000_0000);
    endtask
    task automatic tCsr();
        acc(CMD_MEM_WR, 32'h1000_0010, 4'hc, 32'h1234_5678, 0, 2'b00);
        chk(lat, 1);
        chk({gt, gs}, 2'b11);
        chk(lastOe, 2'b00);
        chk({lastCsrAddr, lastCsrBe}, 16'h010c);
        chk(lastCsrData, 32'h1234_5678);
        n = rdCnt;
        acc(CMD_IO_RD, 32'h0000_203c, 4'hf, 32'h0, 3, 2'b00);
        chk({gt, gs, lat[3:0]}, 6'h31);
        chk(lastOe, 2'b10);
        chk(rdCnt, n + 1);
        chk(rd, 32'hc5a3_e03c);
        acc(CMD_MEM_RD, 32'h1000_0ffc, 4'hf, 32'h0, 0, 2'b00);
        chk(rd, 32'hc5a3_effc);
    endtask
    task automatic tFlash();
        acc(CMD_MEM_RD, 32'h2000_0120, 4'h3, 32'h0, 0, 2'b00);
        chk({gt, gs}, 2'b11);
        chk(lat > FLASH_WAIT_CYC, 1);
        chk(rd, 32'h9120_9120);
        acc(CMD_MEM_WR, 32'h2000_0344, 4'h4, 32'h00a7_0000, 1, 2'b00);
        chk(lat > FLASH_WAIT_CYC, 1);
        chk({gs, lastFlashByte}, 9'h1a7);
        n = fwCnt;
        acc(CMD_MEM_WR, 32'h2000_0344, 4'h3, 32'h0000_5555, 0, 2'b00);
        chk({gs, fwCnt[30:0]}, {1'b1, n[30:0]});
        n = frCnt;
        acc(CMD_MEM_RD, 32'h2000_0120, 4'hf, 32'h0, 0, 2'b00);
        chk({gs, frCnt[30:0]}, {1'b1, n[30:0]});
    endtask
    task automatic tParity();
        acc(CMD_MEM_WR, 32'h1000_0020, 4'hf, 32'h0f0f_0f0f, 0, 2'b10);
        chk({gt, perrSeen, pciStat_ff[STAT_DPE_BIT]}, 3'h7);
        acc(CMD_CFG_WR, 32'h0000_0004, 4'hf, 32'hffff_0143, 0, 2'b00);
        acc(CMD_MEM_RD, 32'h3000_0000, 4'hf, 32'h0, 0, 2'b01);
        chk({serrSeen, pciStat_ff[STAT_SSE_BIT]}, 2'b11);
    endtask
    task automatic tInit();
        for (int i = 0; i < 6; i++) begin
            setSrc(6'(1 << i), 4'(i + 1));
        end
        setSrc(6'h21, 4'h1);
        setSrc(6'h38, 4'h4);
        setSrc(6'h04, 4'h3);
        acc(CMD_CFG_RD, 32'h0000_0010, 4'hf, 32'h0, 0, 2'b00);
        chk({gt, gs}, 2'b01);
        loadPulse();
        acc(CMD_CFG_RD, 32'h0000_0010, 4'hf, 32'h0, 0, 2'b00);
        chk(rd, CSR_MEM_BAR_RST);
        acc(CMD_CFG_WR, 32'h0000_0010, 4'hf, 32'h1000_0000, 0, 2'b00);
        acc(CMD_CFG_RD, 32'h0000_0010, 4'hf, 32'h0, 0, 2'b00);
        chk(rd, 32'h1000_0000);
        @(negedge clk);
        d3ToD0 = 1'b1;
        @(negedge clk);
        d3ToD0 = 1'b0;
        acc(CMD_CFG_RD, 32'h0000_0010, 4'hf, 32'h0, 0, 2'b00);
        chk(rd, CSR_MEM_BAR_RST);
    endtask
    initial begin
        repeat (10) @(negedge clk);
        resetn = 1'b1;
        repeat (4) @(negedge clk);
        tRetry();
        loadPulse();
        tConfig();
        tCsr();
        tFlash();
        tParity();
        tInit();
        finishTest();
    end
endmodule
